// ==== include/cdt_pkg.sv ====
// shared constants and types for the coprocessor transfer address sequencer
// assumes a single 10 MHz core clock and a 32-bit byte address space

// ==========================================================================
// package
package cdt_pkg;

  // widths
  localparam int ADDR_W = 32;
  localparam int OFFS_W = 8;
  localparam int SEL_W = 4;
  localparam int CNT_W = 16;
  localparam int RADDR_W = 8;
  localparam int DATA_W = 32;

  // addressing
  localparam int OFFSET_SHIFT = 2;
  localparam logic [3:0] PC_REG_IDX = 4'hF;
  localparam logic [31:0] PC_AHEAD_BYTES = 32'h0000_0008;
  localparam logic [31:0] WORD_STEP_BYTES = 32'h0000_0004;

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_COST = 8'h10;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ABORT_BIT = 1;
  localparam int STAT_WORDS_LSB = 8;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ABORT_BIT = 1;
  localparam int INT_W = 2;

  // reset values
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [1:0] INT_MASK_RST = 2'h0;

  // bus cycle type shown to the memory system
  typedef enum logic [1:0] {CDT_CYC_NONE, CDT_CYC_I, CDT_CYC_N, CDT_CYC_S} cdt_cyc_e;

  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_XFER, ST_FIN} cdt_state_e;

endpackage

// ==== logic/cdt_agu.sv ====
// address generator for coprocessor transfers: base select, offset scale, indexing
// assumes operands are stable in the cycle the sequencer accepts a transfer

// ==========================================================================
// address generation
module cdt_agu (
  // operands
  input wire logic [31:0] base_value,
  input wire logic [31:0] instr_addr,
  input wire logic [3:0] base_sel,
  input wire logic [7:0] imm_offset,
  // modifiers
  input wire logic up_add,
  input wire logic idx_pre,
  // results
  output logic [31:0] eff_base,
  output logic [31:0] modified_base,
  output logic [31:0] first_addr
);

  logic [31:0] scaled_off;

  // word offset to bytes, pc base reads ahead of the fetch
  always_comb
  begin
    scaled_off = 32'(imm_offset) << cdt_pkg::OFFSET_SHIFT;
    eff_base = (base_sel == cdt_pkg::PC_REG_IDX) ?
               instr_addr + cdt_pkg::PC_AHEAD_BYTES : base_value;
    modified_base = up_add ? eff_base + scaled_off : eff_base - scaled_off;
    first_addr = idx_pre ? modified_base : eff_base;
  end

endmodule

// ==== logic/cdt_copro_xfer.sv ====
// coprocessor data transfer sequencer: addresses, write-back, abort, cycle cost
// assumes decode hands over one instruction at a time and the coprocessor
// answers on the same clock; registers reached over a plain strobe port

// ==========================================================================
// sequencer
module cdt_copro_xfer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // instruction from decode
  input wire logic xfer_start,
  input wire logic cond_pass,
  input wire logic idx_pre,
  input wire logic up_add,
  input wire logic long_len,
  input wire logic wb_req,
  input wire logic is_load,
  input wire logic [3:0] base_sel,
  input wire logic [3:0] copro_number_field,
  input wire logic [3:0] copro_target_register,
  input wire logic [7:0] imm_offset,
  input wire logic [31:0] base_value,
  input wire logic [31:0] instr_addr,
  output logic xfer_ready,
  // base write-back and trap
  output logic wb_en,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_data,
  output logic abort_trap,
  // memory side
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_write,
  output logic [1:0] mem_cyc,
  input wire logic mem_abort,
  // coprocessor side
  output logic cp_active,
  output logic [3:0] cp_number,
  output logic [3:0] cp_target,
  output logic cp_long,
  output logic cp_load,
  input wire logic cp_busy,
  input wire logic cp_last
);

  // ========================================================================
  // state
  cdt_pkg::cdt_state_e state, next_state;
  logic [31:0] addr, next_addr;
  logic [31:0] base, next_base;
  logic [31:0] wb_val, next_wb_val;
  logic [7:0] off, next_off;
  logic [3:0] sel, next_sel, num, next_num, tgt, next_tgt;
  logic lat_u, next_lat_u, lat_p, next_lat_p, lat_n, next_lat_n;
  logic lat_w, next_lat_w, lat_l, next_lat_l;
  logic first, next_first, aborted, next_aborted;
  logic [15:0] i_cnt, next_i_cnt, s_cnt, next_s_cnt, n_cnt, next_n_cnt;
  logic [15:0] words, next_words, cost, next_cost;
  logic ctrl_en, next_ctrl_en;
  logic [1:0] int_stat, next_int_stat, int_mask, next_int_mask;
  logic [31:0] rdata, next_rdata;
  logic [31:0] agu_base, agu_mod, agu_first;
  logic take, pc_base, fin;

  cdt_agu u_agu (
    .base_value(base_value),
    .instr_addr(instr_addr),
    .base_sel(base_sel),
    .imm_offset(imm_offset),
    .up_add(up_add),
    .idx_pre(idx_pre),
    .eff_base(agu_base),
    .modified_base(agu_mod),
    .first_addr(agu_first)
  );

  // handshakes and outputs
  assign xfer_ready = (state == cdt_pkg::ST_IDLE) && ctrl_en;
  assign take = xfer_start && xfer_ready;
  assign pc_base = (sel == cdt_pkg::PC_REG_IDX);
  assign fin = (state == cdt_pkg::ST_FIN);
  assign wb_en = fin && lat_w && !pc_base;
  assign wb_sel = sel;
  assign wb_data = wb_val;
  assign abort_trap = fin && aborted;
  assign mem_req = (state == cdt_pkg::ST_XFER);
  assign mem_addr = addr; // low bits untouched
  assign mem_write = !lat_l;
  assign cp_active = (state != cdt_pkg::ST_IDLE);
  assign cp_number = num;
  assign cp_target = tgt;
  assign cp_long = lat_n;
  assign cp_load = lat_l;
  assign reg_rdata = rdata;
  assign irq = |(int_stat & int_mask);

  // cycle type: busy-wait internal, first word and closing cycle non-sequential
  always_comb
  begin
    case (state)
      cdt_pkg::ST_WAIT: mem_cyc = cp_busy ? cdt_pkg::CDT_CYC_I : cdt_pkg::CDT_CYC_NONE;
      cdt_pkg::ST_XFER: mem_cyc = first ? cdt_pkg::CDT_CYC_N : cdt_pkg::CDT_CYC_S;
      cdt_pkg::ST_FIN: mem_cyc = cdt_pkg::CDT_CYC_N;
      default: mem_cyc = cdt_pkg::CDT_CYC_NONE;
    endcase
  end

  // ========================================================================
  // sequencer next state
  always_comb
  begin
    // grouped like the flops below so defaults and captures stay in step
    next_state = state;
    {next_addr, next_base, next_wb_val} = {addr, base, wb_val};
    {next_off, next_sel, next_num, next_tgt} = {off, sel, num, tgt};
    {next_lat_u, next_lat_p, next_lat_n} = {lat_u, lat_p, lat_n};
    {next_lat_w, next_lat_l, next_first, next_aborted} = {lat_w, lat_l, first, aborted};
    {next_i_cnt, next_s_cnt, next_n_cnt} = {i_cnt, s_cnt, n_cnt};
    {next_words, next_cost} = {words, cost};
    case (state)
      cdt_pkg::ST_IDLE:
      begin
        // a failed condition is taken and dropped without a trace
        if (take && cond_pass)
        begin
          {next_addr, next_base, next_wb_val} = {agu_first, agu_base, agu_mod};
          next_off = imm_offset;
          {next_sel, next_num, next_tgt} = {base_sel, copro_number_field, copro_target_register};
          {next_lat_u, next_lat_p, next_lat_n} = {up_add, idx_pre, long_len};
          {next_lat_w, next_lat_l, next_first, next_aborted} = {wb_req, is_load, 1'h1, 1'h0};
          {next_i_cnt, next_s_cnt, next_n_cnt, next_words} = 64'h0;
          next_state = cdt_pkg::ST_WAIT;
        end
      end
      cdt_pkg::ST_WAIT:
      begin
        if (cp_busy)
          next_i_cnt = i_cnt + 16'h0001;
        else
          next_state = cdt_pkg::ST_XFER;
      end
      cdt_pkg::ST_XFER:
      begin
        // the coprocessor or a memory abort ends the burst, the core only counts
        next_words = words + 16'h0001;
        next_first = 1'h0;
        if (first)
          next_n_cnt = n_cnt + 16'h0001;
        else
          next_s_cnt = s_cnt + 16'h0001;
        if (mem_abort)
        begin
          next_aborted = 1'h1;
          next_state = cdt_pkg::ST_FIN; // write-back still follows
        end
        else if (cp_last)
          next_state = cdt_pkg::ST_FIN;
        else
          next_addr = addr + cdt_pkg::WORD_STEP_BYTES;
      end
      cdt_pkg::ST_FIN:
      begin
        next_cost = i_cnt + s_cnt + n_cnt + 16'h0001;
        next_state = cdt_pkg::ST_IDLE;
      end
      default: next_state = cdt_pkg::ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= cdt_pkg::ST_IDLE;
      {addr, base, wb_val} <= 96'h0;
      {off, sel, num, tgt} <= 20'h00000;
      {lat_u, lat_p, lat_n, lat_w, lat_l, first, aborted} <= 7'h00;
      {i_cnt, s_cnt, n_cnt, words, cost} <= 80'h0;
    end
    else
    begin
      state <= next_state;
      {addr, base, wb_val} <= {next_addr, next_base, next_wb_val};
      {off, sel, num, tgt} <= {next_off, next_sel, next_num, next_tgt};
      {lat_u, lat_p, lat_n} <= {next_lat_u, next_lat_p, next_lat_n};
      {lat_w, lat_l, first, aborted} <= {next_lat_w, next_lat_l, next_first, next_aborted};
      {i_cnt, s_cnt, n_cnt} <= {next_i_cnt, next_s_cnt, next_n_cnt};
      {words, cost} <= {next_words, next_cost};
    end
  end

  // ========================================================================
  // register port and interrupt, event set wins over write-one clear
  always_comb
  begin
    next_ctrl_en = ctrl_en;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    next_rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == cdt_pkg::REG_CTRL)
      next_ctrl_en = reg_wdata[cdt_pkg::CTRL_EN_BIT];
    if (reg_wr && reg_addr == cdt_pkg::REG_INT_MASK)
      next_int_mask = reg_wdata[1:0];
    if (reg_wr && reg_addr == cdt_pkg::REG_INT_STAT)
      next_int_stat = int_stat & ~reg_wdata[1:0];
    next_int_stat[cdt_pkg::INT_DONE_BIT] = next_int_stat[cdt_pkg::INT_DONE_BIT] | fin;
    next_int_stat[cdt_pkg::INT_ABORT_BIT] = next_int_stat[cdt_pkg::INT_ABORT_BIT] | abort_trap;
    if (reg_rd)
    begin
      case (reg_addr)
        cdt_pkg::REG_CTRL: next_rdata = 32'(ctrl_en);
        cdt_pkg::REG_STATUS: next_rdata = (32'(words) << cdt_pkg::STAT_WORDS_LSB)
          | (32'(aborted) << cdt_pkg::STAT_ABORT_BIT) | 32'(cp_active);
        cdt_pkg::REG_INT_STAT: next_rdata = 32'(int_stat);
        cdt_pkg::REG_INT_MASK: next_rdata = 32'(int_mask);
        cdt_pkg::REG_COST: next_rdata = 32'(cost);
        default: next_rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // register file flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_en <= cdt_pkg::CTRL_EN_RST;
      int_mask <= cdt_pkg::INT_MASK_RST;
      int_stat <= 2'h0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl_en <= next_ctrl_en;
      int_mask <= next_int_mask;
      int_stat <= next_int_stat;
      rdata <= next_rdata;
    end
  end

  // ========================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [31:0] chk_off, chk_mod;
  assign chk_off = {22'h000000, off, 2'h0};
  assign chk_mod = lat_u ? base + chk_off : base - chk_off;

  property p_first_addr;
    mem_req && first |-> mem_addr == (lat_p ? chk_mod : base);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first address wrong");

  property p_wb_value;
    wb_en |-> wb_data == chk_mod;
  endproperty
  a_wb_value: assert property (p_wb_value) else $error("write-back value wrong");

  property p_wb_only_w;
    fin && !lat_w |-> !wb_en;
  endproperty
  a_wb_only_w: assert property (p_wb_only_w) else $error("implicit write-back");

  property p_wb_when_w;
    fin && lat_w && sel != cdt_pkg::PC_REG_IDX |-> wb_en && wb_sel == sel;
  endproperty
  a_wb_when_w: assert property (p_wb_when_w) else $error("missing write-back");

  property p_step;
    mem_req && !first |-> mem_addr == $past(mem_addr) + 32'h0000_0004;
  endproperty
  a_step: assert property (p_step) else $error("address step wrong");

  property p_low_bits;
    mem_req && first |-> mem_addr[1:0] == (lat_p ? chk_mod[1:0] : base[1:0]);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low bits altered");

  property p_pc_base;
    take && cond_pass && base_sel == 4'hF |=> base == $past(instr_addr) + 32'h0000_0008;
  endproperty
  a_pc_base: assert property (p_pc_base) else $error("pc base wrong");

  property p_abort;
    mem_req && mem_abort |=> abort_trap && (wb_en == (lat_w && sel != 4'hF));
  endproperty
  a_abort: assert property (p_abort) else $error("abort handling wrong");

  property p_cost;
    fin |=> cost == $past(i_cnt) + $past(words) + 16'h0001;
  endproperty
  a_cost: assert property (p_cost) else $error("cycle cost wrong");

  property p_cond_fail;
    take && !cond_pass |=> state == cdt_pkg::ST_IDLE ##1 !mem_req && !wb_en;
  endproperty
  a_cond_fail: assert property (p_cond_fail) else $error("failed condition acted");

  property p_long;
    cp_active |-> cp_long == lat_n && mem_write == !lat_l;
  endproperty
  a_long: assert property (p_long) else $error("length bit not held");

  c_abort: cover property (mem_req && mem_abort ##1 wb_en);
  c_multi: cover property (mem_req && !first ##1 fin);
  c_pc: cover property (take && cond_pass && base_sel == cdt_pkg::PC_REG_IDX);
  c_busy: cover property (state == cdt_pkg::ST_WAIT && cp_busy [*2]);
endmodule

// ==== sim/cdt_copro_model.sv ====
// stand-in for the attached coprocessor on the far side of the transfer sequencer
// assumes the sequencer's clock and reset; busy length and word counts come from the bench

// ==========================================================================
// coprocessor model
module cdt_copro_model #(
  parameter logic [3:0] OWN_NUM = 4'h3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // sequencer side
  input wire logic cp_active,
  input wire logic [3:0] cp_number,
  input wire logic cp_long,
  input wire logic mem_req,
  output logic cp_busy,
  output logic cp_last,
  // bench settings
  input wire logic [3:0] busy_len,
  input wire logic [3:0] short_words,
  input wire logic [3:0] long_words
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] busy_cnt;
  logic [3:0] word_cnt;
  logic mine;
  logic [3:0] words;
  // only the addressed unit answers; the length bit picks the word count
  assign mine = cp_active && (cp_number == OWN_NUM);
  assign words = cp_long ? long_words : short_words;
  // busy-wait only before the first word, as the sequencer expects
  assign cp_busy = mine && (word_cnt == 4'h0) && !mem_req && (busy_cnt < busy_len);
  assign cp_last = mine && mem_req && (word_cnt == words - 4'h1);
  // counts restart with every transfer, so a retried one replays alike
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_cnt <= 4'h0;
      word_cnt <= 4'h0;
    end
    else if (!mine)
    begin
      busy_cnt <= 4'h0;
      word_cnt <= 4'h0;
    end
    else
    begin
      if (cp_busy)
        busy_cnt <= busy_cnt + 4'h1;
      if (mem_req)
        word_cnt <= word_cnt + 4'h1;
    end
  end
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the coprocessor transfer sequencer
// assumes cdt_pkg is compiled first and the coprocessor model is available

// ==========================================================================
// bench
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic xfer_start = 1'b0;
  logic cond_pass = 1'b0;
  logic idx_pre = 1'b0;
  logic up_add = 1'b0;
  logic long_len = 1'b0;
  logic wb_req = 1'b0;
  logic is_load = 1'b0;
  logic [3:0] base_sel = 4'h0;
  logic [3:0] copro_number_field = 4'h3;
  logic [3:0] copro_target_register = 4'h6;
  logic [7:0] imm_offset = 8'h00;
  logic [31:0] base_value = 32'h0;
  logic [31:0] instr_addr = 32'h0000_4000;
  logic xfer_ready, wb_en, abort_trap, mem_req, mem_write, cp_active;
  logic [3:0] wb_sel, cp_number, cp_target;
  logic [31:0] wb_data, mem_addr;
  logic [1:0] mem_cyc;
  logic mem_abort, cp_long, cp_load, cp_busy, cp_last;
  logic abort_arm = 1'b0;
  logic [3:0] busy_len = 4'h0;
  logic [3:0] short_words = 4'h1;
  logic [3:0] long_words = 4'h1;
  logic [31:0] addr_q[$];
  logic [1:0] cyc_q[$];
  logic wr_seen, wb_same;
  logic ld_seen;
  logic [3:0] tgt_seen, sel_seen;
  logic [31:0] wb_val;
  int wb_cnt, ab_cnt, i_seen, close_cnt;
  int errors = 0;
  int comparisons = 0;

  // the memory system aborts whichever word cycle comes while armed
  assign mem_abort = abort_arm && mem_req;

  cdt_copro_xfer dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .xfer_start, .cond_pass, .idx_pre, .up_add, .long_len, .wb_req, .is_load, .base_sel,
    .copro_number_field, .copro_target_register, .imm_offset, .base_value, .instr_addr,
    .xfer_ready, .wb_en, .wb_sel, .wb_data, .abort_trap, .mem_req, .mem_addr, .mem_write,
    .mem_cyc, .mem_abort, .cp_active, .cp_number, .cp_target, .cp_long, .cp_load, .cp_busy,
    .cp_last);

  cdt_copro_model #(.OWN_NUM(4'h3)) copro_u (.sys_clk, .rst, .cp_active, .cp_number,
    .cp_long, .mem_req, .cp_busy, .cp_last, .busy_len, .short_words, .long_words);

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  // monitor on the falling edge, where every output has settled
  always @(negedge sys_clk)
  begin
    if (mem_req)
    begin
      addr_q.push_back(mem_addr);
      cyc_q.push_back(mem_cyc);
      wr_seen = mem_write;
      ld_seen = cp_load;
      tgt_seen = cp_target;
    end
    if (wb_en)
    begin
      wb_cnt++;
      wb_val = wb_data;
      wb_same = abort_trap;
      sel_seen = wb_sel;
    end
    // busy-wait cycles and the closing non-sequential cycle
    if (mem_cyc == 2'h1)
      i_seen++;
    if (!mem_req && mem_cyc == 2'h2)
      close_cnt++;
    if (abort_trap)
      ab_cnt++;
  end

  // ==========================================================================
  // shared tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // one transfer; the other length gets a different count so a swapped bit shows
  task automatic do_xfer(input logic cond, input logic p, input logic u, input logic n,
    input logic w, input logic l, input logic [3:0] sel, input logic [7:0] off,
    input logic [31:0] base, input logic [3:0] b, input logic [3:0] nw, input logic ab);
    logic [31:0] eb;
    logic [31:0] modb;
    logic [31:0] rd;
    int words;
    int k;
    eb = (sel == 4'hF) ? instr_addr + 32'h0000_0008 : base;
    modb = u ? eb + {22'h0, off, 2'h0} : eb - {22'h0, off, 2'h0};
    words = !cond ? 0 : (ab ? 1 : int'(nw));
    @(posedge sys_clk);
    addr_q.delete();
    cyc_q.delete();
    wb_cnt = 0;
    ab_cnt = 0;
    i_seen = 0;
    close_cnt = 0;
    busy_len <= b;
    short_words <= n ? nw + 4'h1 : nw;
    long_words <= n ? nw : nw + 4'h1;
    abort_arm <= ab;
    xfer_start <= 1'b1;
    cond_pass <= cond;
    idx_pre <= p;
    up_add <= u;
    long_len <= n;
    wb_req <= w;
    is_load <= l;
    base_sel <= sel;
    imm_offset <= off;
    base_value <= base;
    @(posedge sys_clk);
    xfer_start <= 1'b0;
    k = 0;
    @(negedge sys_clk);
    while (!xfer_ready && k < 100)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 100)
    begin
      errors++;
      $display("unexpected hang waiting for the sequencer to go idle");
      end_of_test();
    end
    chk("word count", 32'(words), 32'(addr_q.size()));
    foreach (addr_q[i])
    begin
      chk("word address", (p ? modb : eb) + 32'(i) * 32'h4, addr_q[i]);
      chk("cycle kind", (i == 0) ? 32'h2 : 32'h3, {30'h0, cyc_q[i]});
    end
    if (cond)
    begin
      chk("store direction", {31'h0, !l}, {31'h0, wr_seen});
      chk("load flag", {31'h0, l}, {31'h0, ld_seen});
      chk("target register", 32'h6, {28'h0, tgt_seen});
      reg_read(cdt_pkg::REG_COST, rd);
      chk("cost", 32'(b) + 32'(words) + 32'h1, rd);
      reg_read(cdt_pkg::REG_STATUS, rd);
      chk("status", (32'(words) << 8) | {30'h0, ab, 1'b0}, rd);
    end
    chk("write-back count", (cond && w && sel != 4'hF) ? 32'h1 : 32'h0, 32'(wb_cnt));
    if (wb_cnt == 1)
      chk("write-back value", modb, wb_val);
    if (wb_cnt == 1)
      chk("write-back register", {28'h0, sel}, {28'h0, sel_seen});
    chk("busy cycles", cond ? 32'(b) : 32'h0, 32'(i_seen));
    chk("closing cycles", cond ? 32'h1 : 32'h0, 32'(close_cnt));
    chk("abort trap count", {31'h0, ab}, 32'(ab_cnt));
    if (ab && wb_cnt == 1)
      chk("write-back beside trap", 32'h1, {31'h0, wb_same});
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] rd;
    reg_read(cdt_pkg::REG_CTRL, rd);
    chk("enable reset value", 32'h1, rd);
    reg_read(cdt_pkg::REG_INT_MASK, rd);
    chk("mask reset value", 32'h0, rd);
    reg_write(8'h14, 32'hFFFF_FFFF);
    reg_read(8'h14, rd);
    chk("unmapped read", 32'h0, rd);
    chk("irq idle", 32'h0, {31'h0, irq});
    $display("test registers done");
  endtask

  task automatic t_addressing();
    do_xfer(1, 1, 1, 1, 1, 1, 4'h5, 8'h05, 32'h1000_0002, 4'h2, 4'h3, 0);
    do_xfer(1, 0, 0, 0, 0, 0, 4'h2, 8'hFF, 32'h0000_2000, 4'h0, 4'h1, 0);
    do_xfer(1, 0, 1, 0, 1, 1, 4'h3, 8'h10, 32'h8000_0000, 4'h1, 4'h2, 0);
    do_xfer(1, 1, 0, 1, 0, 0, 4'h3, 8'h10, 32'h8000_0000, 4'h0, 4'h2, 0);
    $display("test addressing done");
  endtask

  task automatic t_pc_base();
    do_xfer(1, 1, 0, 1, 1, 1, 4'hF, 8'h01, 32'hDEAD_0000, 4'h0, 4'h2, 0);
    $display("test program counter base done");
  endtask

  task automatic t_irq();
    logic [31:0] rd;
    reg_write(cdt_pkg::REG_INT_STAT, 32'h3);
    do_xfer(1, 1, 1, 0, 0, 1, 4'h1, 8'h00, 32'h0000_0040, 4'h0, 4'h1, 0);
    reg_read(cdt_pkg::REG_INT_STAT, rd);
    chk("done event", 32'h1, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    reg_write(cdt_pkg::REG_INT_MASK, 32'h1);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    reg_write(cdt_pkg::REG_INT_STAT, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
  endtask

  task automatic t_abort();
    logic [31:0] rd;
    do_xfer(1, 1, 1, 1, 1, 0, 4'h7, 8'h02, 32'h0000_0100, 4'h1, 4'h3, 1);
    abort_arm <= 1'b0;
    reg_read(cdt_pkg::REG_INT_STAT, rd);
    chk("abort event", 32'h2, rd & 32'h2);
    $display("test abort done");
  endtask

  task automatic t_cond_fail();
    do_xfer(0, 1, 1, 1, 1, 1, 4'h4, 8'h08, 32'h0000_3000, 4'h0, 4'h2, 0);
    $display("test failed condition done");
  endtask

  task automatic t_disable();
    reg_write(cdt_pkg::REG_CTRL, 32'h0);
    chk("ready when disabled", 32'h0, {31'h0, xfer_ready});
    addr_q.delete();
    @(posedge sys_clk);
    cond_pass <= 1'b1;
    xfer_start <= 1'b1;
    @(posedge sys_clk);
    xfer_start <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("ignored start", 32'h0, 32'(addr_q.size()));
    reg_write(cdt_pkg::REG_CTRL, 32'h1);
    chk("ready when enabled", 32'h1, {31'h0, xfer_ready});
    $display("test disable done");
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_addressing();
    t_pc_base();
    t_irq();
    t_abort();
    t_cond_fail();
    t_disable();
    end_of_test();
  end
endmodule
